// File: design/sbt_pkg.sv
// shared constants and types of the boundary scan test access port
package sbt_pkg;

    // ========================================================
    // tap controller states, gray coded along the usual path
    typedef enum logic [3:0] {
        SBT_TLR    = 4'h0,
        SBT_RTI    = 4'h1,
        SBT_SEL_DR = 4'h3,
        SBT_CAP_DR = 4'h2,
        SBT_SH_DR  = 4'h6,
        SBT_EX1_DR = 4'h7,
        SBT_PA_DR  = 4'h5,
        SBT_EX2_DR = 4'h4,
        SBT_UPD_DR = 4'hc,
        SBT_SEL_IR = 4'hd,
        SBT_CAP_IR = 4'hf,
        SBT_SH_IR  = 4'he,
        SBT_EX1_IR = 4'ha,
        SBT_PA_IR  = 4'hb,
        SBT_EX2_IR = 4'h9,
        SBT_UPD_IR = 4'h8
    } sbt_state_t;

    // ========================================================
    // three-bit instruction set
    typedef enum logic [2:0] {
        SBT_IR_EXTEST   = 3'h0,
        SBT_IR_IDCODE   = 3'h1,
        SBT_IR_SAMPLE_Z = 3'h2,
        SBT_IR_RSVD3    = 3'h3,
        SBT_IR_SAMPLE   = 3'h4,
        SBT_IR_RSVD5    = 3'h5,
        SBT_IR_RSVD6    = 3'h6,
        SBT_IR_BYPASS   = 3'h7
    } sbt_instr_t;

    // ========================================================
    // register sizes, capture patterns and reset values
    localparam int SBT_IR_W = 3;
    localparam int SBT_ID_W = 32;
    localparam int SBT_BSR_LEN = 90;
    localparam int SBT_BSR_TRI_BIT = 89;
    localparam logic [1:0] SBT_IR_CAPTURE = 2'h1;
    localparam logic SBT_IR_CAPTURE_MSB = 1'h0;
    localparam logic SBT_BYPASS_CAPTURE = 1'h0;
    // arbitrary identification value, lsb set as the scan standard asks
    localparam logic [31:0] SBT_IDCODE_VAL = 32'h0a5a_0001;
    localparam logic SBT_TCK_RST = 1'h0;
    localparam logic SBT_PIN_PULLUP = 1'h1;
    localparam logic [2:0] SBT_RESET_TMS_EDGES = 3'h5;

endpackage

// File: design/sbt_tap_if.sv
// internal carrier between the port core, the controller and the boundary register
`timescale 1ns/10ps
interface sbt_tap_if;
    import sbt_pkg::*;

    logic tick;
    logic tms;
    logic tdi;
    sbt_state_t state;
    logic capture;
    logic shift;
    logic update;
    logic tlr;
    logic [SBT_BSR_LEN-1:0] par_in;
    logic [SBT_BSR_LEN-1:0] par_out;
    logic sout;

    modport ctl (output tick, tms, tdi, capture, shift, update, tlr, par_in, input state, par_out, sout);
    modport fsm (input tick, tms, output state);
    modport bsr (input tdi, capture, shift, update, tlr, par_in, output par_out, sout);
endinterface

// File: design/sbt_tap_fsm.sv
// sixteen-state test access port controller
`timescale 1ns/10ps
module sbt_tap_fsm
    import sbt_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // controller side of the carrier
    sbt_tap_if.fsm tap
);

    sbt_state_t state;
    sbt_state_t next_state;

    // ========================================================
    // next state, moves only on a test clock rising edge
    always_comb begin
        next_state = state;
        if (tap.tick) begin
            case (state)
                // five tms-high rises land here from any state
                SBT_TLR:    next_state = tap.tms ? SBT_TLR : SBT_RTI;
                SBT_RTI:    next_state = tap.tms ? SBT_SEL_DR : SBT_RTI;
                SBT_SEL_DR: next_state = tap.tms ? SBT_SEL_IR : SBT_CAP_DR;
                SBT_CAP_DR: next_state = tap.tms ? SBT_EX1_DR : SBT_SH_DR;
                SBT_SH_DR:  next_state = tap.tms ? SBT_EX1_DR : SBT_SH_DR;
                SBT_EX1_DR: next_state = tap.tms ? SBT_UPD_DR : SBT_PA_DR;
                SBT_PA_DR:  next_state = tap.tms ? SBT_EX2_DR : SBT_PA_DR;
                SBT_EX2_DR: next_state = tap.tms ? SBT_UPD_DR : SBT_SH_DR;
                SBT_UPD_DR: next_state = tap.tms ? SBT_SEL_DR : SBT_RTI;
                // sel-ir with tms high returns to reset
                SBT_SEL_IR: next_state = tap.tms ? SBT_TLR : SBT_CAP_IR;
                SBT_CAP_IR: next_state = tap.tms ? SBT_EX1_IR : SBT_SH_IR;
                SBT_SH_IR:  next_state = tap.tms ? SBT_EX1_IR : SBT_SH_IR;
                SBT_EX1_IR: next_state = tap.tms ? SBT_UPD_IR : SBT_PA_IR;
                SBT_PA_IR:  next_state = tap.tms ? SBT_EX2_IR : SBT_PA_IR;
                SBT_EX2_IR: next_state = tap.tms ? SBT_UPD_IR : SBT_SH_IR;
                SBT_UPD_IR: next_state = tap.tms ? SBT_SEL_DR : SBT_RTI;
                default:    next_state = SBT_TLR;
            endcase
        end
    end

    // ========================================================
    // reset lands in test-logic-reset
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= SBT_TLR;
        end else begin
            state <= next_state;
        end
    end

    assign tap.state = state;

endmodule // sbt_tap_fsm

// File: design/sbt_bsr.sv
// boundary scan register with capture, shift and update stages
`timescale 1ns/10ps
module sbt_bsr
    import sbt_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // register side of the carrier
    sbt_tap_if.bsr tap
);

    logic [SBT_BSR_LEN-1:0] sr;
    logic [SBT_BSR_LEN-1:0] upd;
    logic [SBT_BSR_LEN-1:0] next_sr;
    logic [SBT_BSR_LEN-1:0] next_upd;
    logic [SBT_BSR_LEN-1:0] upd_rst;

    // output-bus enable cell preset high, all others low
    always_comb begin
        upd_rst = '0;
        upd_rst[SBT_BSR_TRI_BIT] = 1'h1;
    end

    // ========================================================
    // capture the pin ring, shift toward the lsb, latch on update
    always_comb begin
        next_sr = sr;
        next_upd = upd;
        if (tap.capture) begin
            next_sr = tap.par_in;
        end else if (tap.shift) begin
            next_sr = {tap.tdi, sr[SBT_BSR_LEN-1:1]};
        end
        if (tap.update) begin
            next_upd = sr;
        end
        // enable cell goes back high in test-logic-reset
        if (tap.tlr) begin
            next_upd[SBT_BSR_TRI_BIT] = 1'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sr <= '0;
            upd <= upd_rst;
        end else begin
            sr <= next_sr;
            upd <= next_upd;
        end
    end

    assign tap.par_out = upd;
    assign tap.sout = sr[0];

endmodule // sbt_bsr

// File: design/sbt_tap_top.sv
// boundary scan test access port: pin sampling, registers, tdo and checks
//
// Operation
// - test access port follows the standard boundary scan architecture
// - holds controller, instruction, boundary scan, bypass and identification registers
// - inputs sampled at tck rise, tdo updated at tck fall, update latch loaded at tck rise
// - controller advances each tck rise according to sampled tms
// - tms weakly pulled up, unconnected reads high
// - tdi weakly pulled up, may stay unconnected
// - exactly one register between tdi and tdo, chosen by instruction
// - serial data enters the msb of the selected register
// - tdo shows the lsb of the selected register
// - tdo driver enabled only while shifting data out
// - power-up enters reset state without disturbing memory
// - five tms-high rising edges reset the controller
// - three-bit instruction register loads identify at reset
// - capture-instruction loads 01 into the two low bits
// - single-bit bypass cleared low under bypass instruction
`timescale 1ns/10ps
module sbt_tap_top
    import sbt_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // test port pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // memory pin ring
    input wire logic [SBT_BSR_LEN-1:0] ring_i,
    output logic [SBT_BSR_LEN-1:0] ring_drive_o,
    output logic extest_o,
    output logic mem_out_en_o
);

    sbt_tap_if tap ();

    // ========================================================
    // pin synchronisers
    logic tck_meta;
    logic tck_sync;
    logic tck_prev;
    logic tms_meta;
    logic tms_sync;
    logic tdi_meta;
    logic tdi_sync;
    logic next_tck_meta;
    logic next_tck_sync;
    logic next_tck_prev;
    logic next_tms_meta;
    logic next_tms_sync;
    logic next_tdi_meta;
    logic next_tdi_sync;
    logic rise;
    logic fall;

    always_comb begin
        next_tck_meta = tck_i;
        next_tck_sync = tck_meta;
        next_tck_prev = tck_sync;
        next_tms_meta = tms_i;
        next_tms_sync = tms_meta;
        next_tdi_meta = tdi_i;
        next_tdi_sync = tdi_meta;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            tck_meta <= SBT_TCK_RST;
            tck_sync <= SBT_TCK_RST;
            tck_prev <= SBT_TCK_RST;
            tms_meta <= SBT_PIN_PULLUP;
            tms_sync <= SBT_PIN_PULLUP;
            tdi_meta <= SBT_PIN_PULLUP;
            tdi_sync <= SBT_PIN_PULLUP;
        end else begin
            tck_meta <= next_tck_meta;
            tck_sync <= next_tck_sync;
            tck_prev <= next_tck_prev;
            tms_meta <= next_tms_meta;
            tms_sync <= next_tms_sync;
            tdi_meta <= next_tdi_meta;
            tdi_sync <= next_tdi_sync;
        end
    end

    // a tck held low gives no edges at all
    assign rise = tck_sync & ~tck_prev;
    assign fall = ~tck_sync & tck_prev;

    // ========================================================
    // controller and boundary register
    sbt_state_t state;

    assign tap.tick = rise;
    assign tap.tms = tms_sync;
    assign tap.tdi = tdi_sync;
    assign state = tap.state;

    sbt_tap_fsm u_fsm (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .tap(tap.fsm)
    );

    sbt_bsr u_bsr (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .tap(tap.bsr)
    );

    // ========================================================
    // instruction register and data register selection
    logic [SBT_IR_W-1:0] ir_sr;
    logic [SBT_IR_W-1:0] next_ir_sr;
    sbt_instr_t ir_q;
    sbt_instr_t next_ir_q;
    logic sel_id;
    logic sel_bsr;
    logic sel_byp;

    // one register per instruction, reserved codes fall to bypass
    always_comb begin
        sel_id = (ir_q == SBT_IR_IDCODE);
        sel_bsr = (ir_q == SBT_IR_EXTEST) || (ir_q == SBT_IR_SAMPLE) || (ir_q == SBT_IR_SAMPLE_Z);
        sel_byp = !sel_id && !sel_bsr;
    end

    always_comb begin
        next_ir_sr = ir_sr;
        next_ir_q = ir_q;
        if (rise) begin
            case (state)
                SBT_CAP_IR: next_ir_sr = {SBT_IR_CAPTURE_MSB, SBT_IR_CAPTURE};
                SBT_SH_IR: next_ir_sr = {tdi_sync, ir_sr[SBT_IR_W-1:1]};
                SBT_UPD_IR: next_ir_q = sbt_instr_t'(ir_sr);
                default: next_ir_sr = ir_sr;
            endcase
        end
        if (state == SBT_TLR) begin
            next_ir_q = SBT_IR_IDCODE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ir_sr <= SBT_IR_IDCODE;
            ir_q <= SBT_IR_IDCODE;
        end else begin
            ir_sr <= next_ir_sr;
            ir_q <= next_ir_q;
        end
    end

    // ========================================================
    // identification and bypass registers
    logic [SBT_ID_W-1:0] id_sr;
    logic [SBT_ID_W-1:0] next_id_sr;
    logic byp;
    logic next_byp;

    always_comb begin
        next_id_sr = id_sr;
        next_byp = byp;
        if (rise && state == SBT_CAP_DR) begin
            if (sel_id) begin
                next_id_sr = SBT_IDCODE_VAL;
            end
            if (sel_byp) begin
                next_byp = SBT_BYPASS_CAPTURE;
            end
        end else if (rise && state == SBT_SH_DR) begin
            if (sel_id) begin
                next_id_sr = {tdi_sync, id_sr[SBT_ID_W-1:1]};
            end
            if (sel_byp) begin
                next_byp = tdi_sync;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            id_sr <= '0;
            byp <= SBT_BYPASS_CAPTURE;
        end else begin
            id_sr <= next_id_sr;
            byp <= next_byp;
        end
    end

    // boundary register strobes, only when it is the selected path
    assign tap.capture = rise && (state == SBT_CAP_DR) && sel_bsr;
    assign tap.shift = rise && (state == SBT_SH_DR) && sel_bsr;
    assign tap.update = rise && (state == SBT_UPD_DR) && sel_bsr;
    assign tap.tlr = (state == SBT_TLR);
    assign tap.par_in = ring_i;

    // ========================================================
    // test data out, changes only on the falling tck edge
    logic next_tdo;
    logic next_tdo_oe;
    logic dr_lsb;
    logic shifting;

    always_comb begin
        if (sel_id) begin
            dr_lsb = id_sr[0];
        end else if (sel_bsr) begin
            dr_lsb = tap.sout;
        end else begin
            dr_lsb = byp;
        end
        shifting = (state == SBT_SH_IR) || (state == SBT_SH_DR);
        next_tdo = tdo_o;
        next_tdo_oe = tdo_oe_o;
        if (fall) begin
            next_tdo_oe = shifting;
            next_tdo = (state == SBT_SH_IR) ? ir_sr[0] : dr_lsb;
        end
    end

    // tdo comes up released after power-up
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            tdo_o <= 1'h0;
            tdo_oe_o <= 1'h0;
        end else begin
            tdo_o <= next_tdo;
            tdo_oe_o <= next_tdo_oe;
        end
    end

    // ========================================================
    // memory-side controls; memory untouched unless extest or sample-z
    logic next_extest;
    logic next_mem_out_en;

    // memory keeps normal outputs in reset state
    always_comb begin
        next_extest = (ir_q == SBT_IR_EXTEST);
        if (ir_q == SBT_IR_EXTEST) begin
            next_mem_out_en = tap.par_out[SBT_BSR_TRI_BIT];
        end else if (ir_q == SBT_IR_SAMPLE_Z) begin
            next_mem_out_en = 1'h0;
        end else begin
            next_mem_out_en = 1'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            extest_o <= 1'h0;
            mem_out_en_o <= 1'h1;
        end else begin
            extest_o <= next_extest;
            mem_out_en_o <= next_mem_out_en;
        end
    end

    // update latch is itself a flop inside the boundary register
    assign ring_drive_o = tap.par_out;

    // ========================================================
    // checks: consecutive tms-high rising edges, saturating
    logic [2:0] tms_cnt;
    logic [2:0] next_tms_cnt;

    always_comb begin
        next_tms_cnt = tms_cnt;
        if (rise) begin
            if (!tms_sync) begin
                next_tms_cnt = 3'h0;
            end else if (tms_cnt != SBT_RESET_TMS_EDGES) begin
                next_tms_cnt = tms_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            tms_cnt <= 3'h0;
        end else begin
            tms_cnt <= next_tms_cnt;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_rise_in(sbt_state_t st);
        rise && (state == st);
    endsequence

    sequence s_fall_shift;
        fall && ((state == SBT_SH_IR) || (state == SBT_SH_DR));
    endsequence

    AST_RESET_TLR: assert property (disable iff (1'b0) srst_i |=> state == SBT_TLR)
        else $error("controller not in reset state after reset");
    AST_FIVE_TMS_RESET: assert property (tms_cnt == SBT_RESET_TMS_EDGES |-> state == SBT_TLR)
        else $error("five tms-high edges did not reset the controller");
    AST_NO_EDGE_HOLD: assert property (!rise |=> $stable(state))
        else $error("controller moved without a tck rise");
    AST_TLR_IDCODE: assert property (state == SBT_TLR |=> ir_q == SBT_IR_IDCODE)
        else $error("instruction not identify in reset state");
    AST_CAPIR_PATTERN: assert property (s_rise_in(SBT_CAP_IR) |=> ir_sr[1:0] == SBT_IR_CAPTURE)
        else $error("capture-instruction pattern wrong");
    AST_BYPASS_LOW: assert property (s_rise_in(SBT_CAP_DR) ##0 sel_byp |=> !byp)
        else $error("bypass not cleared on capture");
    AST_SHIFT_MSB: assert property (s_rise_in(SBT_SH_IR) |=> ir_sr[SBT_IR_W-1] == $past(tdi_sync))
        else $error("tdi not shifted into msb");
    AST_TDO_OE: assert property (s_fall_shift |=> tdo_oe_o ##1 (tdo_oe_o || fall))
        else $error("tdo driver not enabled while shifting");
    AST_TDO_OFF: assert property (fall && !((state == SBT_SH_IR) || (state == SBT_SH_DR)) |=> !tdo_oe_o)
        else $error("tdo driven outside shift states");
    AST_TDO_ON_FALL: assert property (!fall |=> $stable(tdo_o) && $stable(tdo_oe_o))
        else $error("tdo changed away from a tck fall");
    AST_TDO_LSB: assert property (fall && state == SBT_SH_DR && sel_byp |=> tdo_o == $past(byp))
        else $error("tdo not the lsb of bypass");

endmodule // sbt_tap_top

// File: verification/sbt_jtag_ctl.sv
// board-side scan controller model that drives the test port pins
`timescale 1ns/10ps
module sbt_jtag_ctl (
    // clock
    input wire logic core_clk_i,
    // test port pins
    input wire logic tdo_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic drive_o
);
    // ========================================================
    // parked levels: clock low, data pins released
    // tck stands low
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h0;
        tdi_o = 1'h0;
        drive_o = 1'h0;
    end

    // ========================================================
    // one 80 ns tck period; tdo is taken just before the rise, as a real controller does
    // tms per rise
    task automatic tick(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        repeat (4) @(negedge core_clk_i);
        q = tdo_i;
        tck_o = 1'h1;
        repeat (4) @(negedge core_clk_i);
        tck_o = 1'h0;
    endtask

    // five tms-high rises, then one low rise into run-test-idle
    // five ones reset
    task automatic reset5(input logic drv);
        logic q;
        drive_o = drv;
        repeat (5) tick(drv, 1'h0, q);
        drive_o = 1'h1;
        tick(1'h0, 1'h0, q);
        drive_o = 1'h0;
    endtask

    // idle to shift, n bits lsb first, update, back to idle; pins released afterwards
    // standard tms walk
    task automatic scan(input logic ir, input logic [127:0] din, input int n, output logic [127:0] dout);
        logic q;
        dout = '0;
        drive_o = 1'h1;
        tick(1'h1, 1'h0, q);
        if (ir) begin
            tick(1'h1, 1'h0, q);
        end
        tick(1'h0, 1'h0, q);
        tick(1'h0, 1'h0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'h1, 1'h0, q);
        tick(1'h0, 1'h0, q);
        drive_o = 1'h0;
        // clock parked: lets the registered outputs settle before anyone looks
        repeat (4) @(negedge core_clk_i);
    endtask
endmodule // sbt_jtag_ctl

// File: verification/testbench.sv
// self-checking bench of the boundary scan test port
`timescale 1ns/10ps
module testbench;
    import sbt_pkg::*;
    logic core_clk_i;
    logic srst_i;
    logic tck, tms_drv, tdi_drv, drive, tms_pin, tdi_pin, tdo_o, tdo_oe_o, extest_o, mem_out_en_o;
    wire tdo_pin;
    logic [SBT_BSR_LEN-1:0] ring_i;
    logic [SBT_BSR_LEN-1:0] ring_drive_o;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    // ========================================================
    // pin resolution: released inputs float high, tdo floats when not driven
    assign tms_pin = drive ? tms_drv : 1'h1;
    assign tdi_pin = drive ? tdi_drv : 1'h1;
    assign tdo_pin = tdo_oe_o ? tdo_o : 1'hz;

    sbt_tap_top DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .tck_i(tck), .tms_i(tms_pin),
        .tdi_i(tdi_pin), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ring_i(ring_i),
        .ring_drive_o(ring_drive_o), .extest_o(extest_o), .mem_out_en_o(mem_out_en_o));

    sbt_jtag_ctl u_ctl (.core_clk_i(core_clk_i), .tdo_i(tdo_pin), .tck_o(tck), .tms_o(tms_drv),
        .tdi_o(tdi_drv), .drive_o(drive));

    // 100 MHz core clock
    initial begin
        core_clk_i = 1'h0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ========================================================
    // reporting
    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 2600 cycles the run needs
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            errors = errors + 1;
            summarize();
        end
    end

    // ========================================================
    // scenarios
    task automatic load_ir(input logic [2:0] code);
        logic [127:0] d;
        u_ctl.scan(1'h1, {125'h0, code}, 3, d);
        check("ir capture", d[2:0], {SBT_IR_CAPTURE_MSB, SBT_IR_CAPTURE});
    endtask

    // after reset: tdo floats and the default instruction reads the id word
    task automatic t_power_up();
        logic [127:0] d;
        check("tdo idle", tdo_pin, 1'hz);
        check("oe idle", tdo_oe_o, 1'h0);
        check("mem enable", mem_out_en_o, 1'h1);
        // controller wakes in test-logic-reset; scans start from run-test-idle
        u_ctl.reset5(1'h1);
        u_ctl.scan(1'h0, 128'h1, 33, d);
        check("id word", d[31:0], SBT_IDCODE_VAL);
        check("tdi at msb", d[32], 1'h1);
        check("tdo after scan", tdo_pin, 1'hz);
        $display("test power_up done");
    endtask

    // ir is three bits long; bypass and reserved codes give a one-stage path
    task automatic t_bypass();
        logic [127:0] d;
        logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        u_ctl.scan(1'h1, {122'h0, 3'h7, 3'h4}, 6, d);
        check("ir out", d[5:0], {3'h4, SBT_IR_CAPTURE_MSB, SBT_IR_CAPTURE});
        foreach (codes[k]) begin
            load_ir(codes[k]);
            u_ctl.scan(1'h0, 128'h5a, 8, d);
            check("bypass capture", d[0], SBT_BYPASS_CAPTURE);
            check("bypass path", d[7:1], 7'h5a);
        end
        $display("test bypass done");
    endtask

    // sample, preload, then extest acting on the enable cell and sample-z forcing the memory enable low
    task automatic t_boundary();
        logic [127:0] d;
        logic [127:0] din;
        din = 128'h1234_5678_9abc_def0_1357_9bdf_0246_8ace;
        ring_i = 90'h2_3456_789a_bcde_f012_3456_7;
        load_ir(SBT_IR_SAMPLE);
        u_ctl.scan(1'h0, din, 94, d);
        check("ring capture", d[89:0], ring_i);
        check("bsr length", d[93:90], din[3:0]);
        check("preload", ring_drive_o, din[93:4]);
        check("sample enable", mem_out_en_o, 1'h1);
        load_ir(SBT_IR_EXTEST);
        check("extest flag", extest_o, 1'h1);
        check("enable cell", mem_out_en_o, din[93]);
        load_ir(SBT_IR_SAMPLE_Z);
        check("sample z", mem_out_en_o, 1'h0);
        check("extest off", extest_o, 1'h0);
        $display("test boundary done");
    endtask

    // released pins read high through pull-ups; five rises return to reset
    task automatic t_reset();
        logic [127:0] d;
        u_ctl.reset5(1'h0);
        repeat (4) @(negedge core_clk_i);
        check("cell preset", ring_drive_o[SBT_BSR_TRI_BIT], 1'h1);
        check("memory enabled", mem_out_en_o, 1'h1);
        check("tdo idle", tdo_pin, 1'hz);
        u_ctl.scan(1'h0, 128'h0, 32, d);
        check("id after reset", d[31:0], SBT_IDCODE_VAL);
        $display("test reset done");
    endtask

    // ========================================================
    // main sequence
    initial begin
        srst_i = 1'h1;
        ring_i = '0;
        repeat (16) @(negedge core_clk_i);
        srst_i = 1'h0;
        repeat (4) @(negedge core_clk_i);
        t_power_up();
        t_bypass();
        t_boundary();
        t_reset();
        summarize();
    end
endmodule // testbench
